// ===== logic/sbfd_rx.v
// Receive framer, 8B/10B decoder and ready strobe with an APB control port
`timescale 1ns/100ps
//
// Functional notes
// R01 - Shift serial bits, load character every ten bits
// R02 - Comma detection resets bit counter, aligning bytes
// R03 - Reframe low inhibits framer realignment
// R04 - After reframe rises, no strobes until comma
// R05 - Encoded mode gives byte, special and violation
// R06 - Sent violation symbol flagged like line error
// R07 - Bypass copies ten raw bits to outputs
// R08 - Bypass framing identical to encoded mode
// R09 - Outputs change together, aligned with strobes
// R10 - Ready low sixty percent of byte period
// R11 - Ready staying high marks ignorable pad
// R12 - Comma followed by comma is unstrobed fill
// R13 - Comma followed by other character is strobed
// R14 - Bypass with reframe strobes once per comma
// R15 - Host captures on byte clock or ready
// R16 - Bypass encoder guarantees transitions per character
// R17 - Reframe sampled at byte clock falling edge
// R18 - Unencoded mode strobes when comma at outputs
// R19 - Unassigned code gives violation, special, E0
// R20 - Mode low decodes, mode high bypasses
// R21 - Reset clears state, ready high until data
`include "sbfd_consts.vh"

module sbfd_rx
(
   input wire REF_CLK,
   input wire RESET,
   input wire SERIAL_IN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [11:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR,
   output reg [7:0] DECODED_BYTE,
   output reg SPECIAL_CHAR_FLAG,
   output reg RECEIVED_VIOLATION,
   output reg [9:0] RAW_CHAR_BITS,
   output reg OUTPUT_READY_N,
   output reg RECOVERED_BYTE_CLOCK
);

   // ***************************************************
   // Decode tables
   // ***************************************************
   function [5:0] dec6;
      input [5:0] s;
      begin
         case (s)
            6'h27, 6'h18: dec6 = {1'b1, 5'h00};
            6'h1D, 6'h22: dec6 = {1'b1, 5'h01};
            6'h2D, 6'h12: dec6 = {1'b1, 5'h02};
            6'h31: dec6 = {1'b1, 5'h03};
            6'h35, 6'h0A: dec6 = {1'b1, 5'h04};
            6'h29: dec6 = {1'b1, 5'h05};
            6'h19: dec6 = {1'b1, 5'h06};
            6'h38, 6'h07: dec6 = {1'b1, 5'h07};
            6'h39, 6'h06: dec6 = {1'b1, 5'h08};
            6'h25: dec6 = {1'b1, 5'h09};
            6'h15: dec6 = {1'b1, 5'h0A};
            6'h34: dec6 = {1'b1, 5'h0B};
            6'h0D: dec6 = {1'b1, 5'h0C};
            6'h2C: dec6 = {1'b1, 5'h0D};
            6'h1C: dec6 = {1'b1, 5'h0E};
            6'h17, 6'h28: dec6 = {1'b1, 5'h0F};
            6'h1B, 6'h24: dec6 = {1'b1, 5'h10};
            6'h23: dec6 = {1'b1, 5'h11};
            6'h13: dec6 = {1'b1, 5'h12};
            6'h32: dec6 = {1'b1, 5'h13};
            6'h0B: dec6 = {1'b1, 5'h14};
            6'h2A: dec6 = {1'b1, 5'h15};
            6'h1A: dec6 = {1'b1, 5'h16};
            6'h3A, 6'h05: dec6 = {1'b1, 5'h17};
            6'h33, 6'h0C: dec6 = {1'b1, 5'h18};
            6'h26: dec6 = {1'b1, 5'h19};
            6'h16: dec6 = {1'b1, 5'h1A};
            6'h36, 6'h09: dec6 = {1'b1, 5'h1B};
            6'h0E, 6'h0F, 6'h30: dec6 = {1'b1, 5'h1C};
            6'h2E, 6'h11: dec6 = {1'b1, 5'h1D};
            6'h1E, 6'h21: dec6 = {1'b1, 5'h1E};
            6'h2B, 6'h14: dec6 = {1'b1, 5'h1F};
            default: dec6 = {1'b0, 5'h00};
         endcase
      end
   endfunction

   function [3:0] dec4;
      input [3:0] s;
      begin
         case (s)
            4'hB, 4'h4: dec4 = {1'b1, 3'h0};
            4'h9: dec4 = {1'b1, 3'h1};
            4'h5: dec4 = {1'b1, 3'h2};
            4'hC, 4'h3: dec4 = {1'b1, 3'h3};
            4'hD, 4'h2: dec4 = {1'b1, 3'h4};
            4'hA: dec4 = {1'b1, 3'h5};
            4'h6: dec4 = {1'b1, 3'h6};
            4'hE, 4'h1, 4'h7, 4'h8: dec4 = {1'b1, 3'h7};
            default: dec4 = {1'b0, 3'h0};
         endcase
      end
   endfunction

   // Alternate x.7 special forms; low bits pick the special code
   function [2:0] alt7;
      input [5:0] s;
      begin
         case (s)
            6'h3A, 6'h05: alt7 = {1'b1, 2'h0};
            6'h36, 6'h09: alt7 = {1'b1, 2'h1};
            6'h2E, 6'h11: alt7 = {1'b1, 2'h2};
            6'h1E, 6'h21: alt7 = {1'b1, 2'h3};
            default: alt7 = {1'b0, 2'h0};
         endcase
      end
   endfunction

   // ***************************************************
   // State
   // ***************************************************
   reg [9:0] shift_ff;
   reg [3:0] bit_cnt_ff;
   reg [9:0] dec_reg_ff;
   reg dec_valid_ff;
   reg strobe_ok_ff;
   reg hunt_ff;
   reg rf_ff;
   reg byp_ff;
   reg [1:0] ctrl_ff;
   wire [9:0] nxt_shift;
   wire comma_now;
   wire load;
   wire [3:0] nxt_cnt;
   wire nxt_byte_clk;
   wire byte_fall;
   wire [5:0] d6;
   wire [3:0] d4;
   wire k28;
   wire k_alt;
   wire is_comma;
   wire [5:0] r6;
   wire [3:0] r4;
   wire dec_ok;
   wire [2:0] a7;
   reg [7:0] dec_byte;
   wire dec_special;
   wire next_is_comma;
   wire nxt_strobe;

   assign nxt_shift = {shift_ff[8:0], SERIAL_IN}; // [R01]
   // Comma window includes the bit arriving now so the load lands on it
   assign comma_now = (nxt_shift == `SBFD_COMMA_NEG) || (nxt_shift == `SBFD_COMMA_POS); // [R02]
   // Framer alias risk on noisy lines is why realignment is gated
   assign load = (bit_cnt_ff == `SBFD_LAST_BIT) || (comma_now && rf_ff); // [R01] [R03] [R08]
   assign nxt_cnt = load ? 4'h0 : bit_cnt_ff + 4'h1; // [R02]
   assign nxt_byte_clk = (nxt_cnt < `SBFD_CLK_HIGH_BITS);
   assign byte_fall = RECOVERED_BYTE_CLOCK && !nxt_byte_clk;

   // ***************************************************
   // Character decode
   // ***************************************************
   assign r6 = dec_reg_ff[9:4];
   assign r4 = dec_reg_ff[3:0];
   assign k28 = (r6 == `SBFD_K28_NEG) || (r6 == `SBFD_K28_POS);
   assign d6 = dec6(r6);
   // The positive-disparity K28 form carries an inverted 4b group
   assign d4 = dec4((r6 == `SBFD_K28_POS) ? ~r4 : r4);
   assign a7 = alt7(r6);
   assign k_alt = a7[2] && (r4 == 4'h8 || r4 == 4'h7);
   assign is_comma = (dec_reg_ff == `SBFD_COMMA_NEG) || (dec_reg_ff == `SBFD_COMMA_POS);
   // Successor is the full character completing at this load
   assign next_is_comma = comma_now; // [R12]
   // Any code outside the tables, the sent violation symbol included
   assign dec_ok = d6[5] && d4[3]; // [R06] [R19]
   assign dec_special = k28 || k_alt; // [R05]

   always @*
   begin
      dec_byte = {d4[2:0], d6[4:0]}; // [R05]
      if (!dec_ok)
      begin
         dec_byte = `SBFD_BAD_CODE; // [R19]
      end
      else if (k28)
      begin
         dec_byte = {5'h00, d4[2:0]};
      end
      else if (k_alt)
      begin
         dec_byte = {6'h02, a7[1:0]};
      end
   end

   // Strobe for the character moving to the outputs; its successor
   // is already known, which settles the fill decision.
   assign nxt_strobe = dec_valid_ff && !hunt_ff &&
      (byp_ff ? is_comma : !(is_comma && next_is_comma)); // [R04] [R12] [R13] [R14] [R18]

   // ***************************************************
   // Framing and character pipeline
   // ***************************************************
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         shift_ff <= 10'h000;
         bit_cnt_ff <= 4'h0;
         dec_reg_ff <= 10'h000;
         dec_valid_ff <= 1'b0;
         strobe_ok_ff <= 1'b0;
         byp_ff <= 1'b0;
         RECOVERED_BYTE_CLOCK <= 1'b0;
         OUTPUT_READY_N <= 1'b1; // [R21]
         DECODED_BYTE <= 8'h00;
         SPECIAL_CHAR_FLAG <= 1'b0;
         RECEIVED_VIOLATION <= 1'b0;
         RAW_CHAR_BITS <= 10'h000;
      end
      else
      begin
         shift_ff <= nxt_shift; // [R01]
         bit_cnt_ff <= nxt_cnt; // [R02]
         RECOVERED_BYTE_CLOCK <= nxt_byte_clk;
         if (load)
         begin
            dec_reg_ff <= nxt_shift; // [R01]
            dec_valid_ff <= 1'b1;
            byp_ff <= ctrl_ff[`SBFD_CTRL_BYP_BIT]; // [R20]
            strobe_ok_ff <= nxt_strobe;
            // All outputs move on the same edge as the strobe start
            RAW_CHAR_BITS <= dec_reg_ff; // [R07] [R09]
            if (ctrl_ff[`SBFD_CTRL_BYP_BIT] || byp_ff)
            begin
               DECODED_BYTE <= 8'h00; // [R07]
               SPECIAL_CHAR_FLAG <= 1'b0;
               RECEIVED_VIOLATION <= 1'b0;
            end
            else
            begin
               DECODED_BYTE <= dec_byte; // [R05] [R09]
               SPECIAL_CHAR_FLAG <= dec_special || !dec_ok; // [R05] [R19]
               RECEIVED_VIOLATION <= !dec_ok; // [R06] [R19]
            end
            OUTPUT_READY_N <= !(nxt_strobe && dec_valid_ff); // [R10] [R11] [R21]
         end
         else
            OUTPUT_READY_N <= !(strobe_ok_ff && nxt_cnt < `SBFD_READY_LOW_BITS); // [R10]
      end
   end

   // ***************************************************
   // Reframe sampling and hunt
   // ***************************************************
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         rf_ff <= 1'b0;
         hunt_ff <= 1'b0;
      end
      else
      begin
         if (byte_fall)
         begin
            rf_ff <= ctrl_ff[`SBFD_CTRL_RF_BIT]; // [R17]
         end
         // Set wins over a coincident comma, so a fresh rise always hunts
         if (byte_fall && ctrl_ff[`SBFD_CTRL_RF_BIT] && !rf_ff)
         begin
            hunt_ff <= 1'b1; // [R04]
         end
         else if (comma_now && rf_ff && hunt_ff)
         begin
            hunt_ff <= 1'b0; // [R04]
         end
      end
   end

   // ***************************************************
   // APB slave, no wait states
   // ***************************************************
   wire apb_setup;
   wire apb_access;
   wire hit_ctrl;
   wire hit_stat;
   wire hit_data;

   assign apb_setup = PSEL && !PENABLE;
   assign apb_access = PSEL && PENABLE && PREADY;
   assign hit_ctrl = (PADDR == `SBFD_CTRL_OFS);
   assign hit_stat = (PADDR == `SBFD_STAT_OFS);
   assign hit_data = (PADDR == `SBFD_DATA_OFS);

   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         PREADY <= 1'b0;
         PRDATA <= 32'h00000000;
         PSLVERR <= 1'b0;
      end
      else if (apb_setup)
      begin
         PREADY <= 1'b1;
         PSLVERR <= !(hit_ctrl || hit_stat || hit_data);
         if (PWRITE)
            PRDATA <= 32'h00000000;
         else if (hit_ctrl)
            PRDATA <= {30'h00000000, ctrl_ff};
         else if (hit_stat)
            PRDATA <= {28'h0000000, dec_valid_ff, byp_ff, rf_ff, hunt_ff};
         else if (hit_data)
            PRDATA <= {12'h000, RECEIVED_VIOLATION, SPECIAL_CHAR_FLAG,
               DECODED_BYTE, RAW_CHAR_BITS};
         else
            PRDATA <= 32'h00000000;
      end
      else
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
   end

   // Control commits in the access phase, at the edge the master samples
   always @(posedge REF_CLK)
   begin
      if (RESET)
      begin
         ctrl_ff <= `SBFD_CTRL_RST;
      end
      else if (apb_access && PWRITE && hit_ctrl)
      begin
         ctrl_ff <= PWDATA[1:0];
      end
   end

endmodule // sbfd_rx

// ===== logic/sbfd_consts.vh
// Constants for the serial byte framer and decoder receive block
`ifndef SBFD_CONSTS_VH
`define SBFD_CONSTS_VH

// APB register byte offsets
`define SBFD_CTRL_OFS 12'h000
`define SBFD_STAT_OFS 12'h004
`define SBFD_DATA_OFS 12'h008

// Control field positions and reset value
`define SBFD_CTRL_RF_BIT 0
`define SBFD_CTRL_BYP_BIT 1
`define SBFD_CTRL_RST 2'h0

// Character timing in bit times
`define SBFD_BITS_PER_CHAR 4'hA
`define SBFD_LAST_BIT 4'h9
`define SBFD_READY_LOW_BITS 4'h6
`define SBFD_CLK_HIGH_BITS 4'h5

// Comma patterns, bit a in the top position
`define SBFD_COMMA_NEG 10'h0FA
`define SBFD_COMMA_POS 10'h305
`define SBFD_K28_NEG 6'h0F
`define SBFD_K28_POS 6'h30

// Decoded special codes
`define SBFD_FILL_CODE 8'h05
`define SBFD_BAD_CODE 8'hE0

`endif

// ===== bench/sbfd_props.sv
// Port checker for the receive framer and decoder
`timescale 1ns/100ps
module sbfd_props
(
   input wire REF_CLK,
   input wire RESET,
   input wire PSEL,
   input wire PENABLE,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR,
   input wire [7:0] DECODED_BYTE,
   input wire SPECIAL_CHAR_FLAG,
   input wire RECEIVED_VIOLATION,
   input wire [9:0] RAW_CHAR_BITS,
   input wire OUTPUT_READY_N,
   input wire RECOVERED_BYTE_CLOCK
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   // ****
   // Character path
   // ****
   chk_ready_low_six: assert property ($fell(OUTPUT_READY_N) |->
      !OUTPUT_READY_N [*6] ##1 OUTPUT_READY_N) else $error("ready low time wrong");
   chk_strobe_with_clock: assert property ($fell(OUTPUT_READY_N) |->
      $rose(RECOVERED_BYTE_CLOCK)) else $error("ready fell off the byte clock");
   chk_outputs_at_load: assert property ($changed({DECODED_BYTE, SPECIAL_CHAR_FLAG,
      RECEIVED_VIOLATION, RAW_CHAR_BITS}) |-> RECOVERED_BYTE_CLOCK &&
      ($rose(RECOVERED_BYTE_CLOCK) || OUTPUT_READY_N))
      else $error("outputs moved between loads");
   chk_violation_code: assert property (RECEIVED_VIOLATION |->
      SPECIAL_CHAR_FLAG && DECODED_BYTE == 8'hE0) else $error("violation code wrong");
   // ****
   // Register port
   // ****
   chk_apb_answer: assert property (PSEL && !PENABLE |=> PREADY)
      else $error("no answer after setup");
   chk_ready_one_cycle: assert property (PREADY |=> !PREADY) else $error("ready too long");
   chk_error_with_ready: assert property (PSLVERR |-> PREADY) else $error("stray error");
   chk_error_no_data: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("error data");
   cover property ($fell(OUTPUT_READY_N));
   cover property (RECEIVED_VIOLATION && $rose(RECOVERED_BYTE_CLOCK));
   cover property (PSLVERR);
endmodule // sbfd_props

bind sbfd_rx sbfd_props i_props (.REF_CLK(REF_CLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .DECODED_BYTE(DECODED_BYTE), .SPECIAL_CHAR_FLAG(SPECIAL_CHAR_FLAG),
   .RECEIVED_VIOLATION(RECEIVED_VIOLATION), .RAW_CHAR_BITS(RAW_CHAR_BITS),
   .OUTPUT_READY_N(OUTPUT_READY_N), .RECOVERED_BYTE_CLOCK(RECOVERED_BYTE_CLOCK));

// ===== bench/sbfd_tx_model.sv
// Far-end serial transmitter model
`timescale 1ns/100ps
module sbfd_tx_model
(
   input wire clk,
   input wire rst,
   output reg ser
);
   logic [9:0] q [$];
   logic [9:0] sh_ff;
   logic [3:0] cnt_ff;
   // Idle sends an alternating character, so the line always toggles
   always @(posedge clk)
   begin
      if (rst)
      begin
         cnt_ff <= 4'h0;
         sh_ff <= 10'h2AA;
         ser <= 1'b0;
      end
      else
      begin
         ser <= sh_ff[9];
         if (cnt_ff == 4'h9)
         begin
            cnt_ff <= 4'h0;
            sh_ff <= (q.size() != 0) ? q.pop_front() : 10'h2AA;
         end
         else
         begin
            cnt_ff <= cnt_ff + 4'h1;
            sh_ff <= {sh_ff[8:0], 1'b0};
         end
      end
   end
endmodule // sbfd_tx_model

// ===== bench/tb.sv
// Testbench for the receive framer and decoder
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, ser, byte_clk, rdy_n, spec, viol, err, prev = 1'b1;
   logic [7:0] dbyte;
   logic [9:0] raw;
   logic [27:0] seen [0:63];
   int ns = 0, err_count = 0, compares = 0;
   always #12.5 ref_clk = ~ref_clk;
   sbfd_rx i_dut (.REF_CLK(ref_clk), .RESET(reset), .SERIAL_IN(ser), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .DECODED_BYTE(dbyte), .SPECIAL_CHAR_FLAG(spec),
      .RECEIVED_VIOLATION(viol), .RAW_CHAR_BITS(raw), .OUTPUT_READY_N(rdy_n),
      .RECOVERED_BYTE_CLOCK(byte_clk));
   sbfd_tx_model i_tx (.clk(ref_clk), .rst(reset), .ser(ser));
   // Host side: one capture per fall of ready, on the clock
   always @(posedge ref_clk)
   begin
      if (prev === 1'b1 && rdy_n === 1'b0 && ns < 64)
         seen[ns++] = {viol, spec, dbyte, raw};
      prev <= rdy_n;
   end
   task automatic chk(input logic [27:0] got, exp, input string nm);
      compares++;
      if (got !== exp)
      begin
         $display("unexpected %s expected %h seen %h", nm, exp, got);
         err_count++;
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge ref_clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, wd};
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1 && ++n < 50);
      rd = prdata;
      err = pslverr;
      if (n >= 50) err_count++;
      {psel, penable} <= 2'b00;
   endtask
   task automatic send(input logic [9:0] c [6]);
      int n;
      n = 0;
      foreach (c[i]) i_tx.q.push_back(c[i]);
      while (i_tx.q.size() != 0 && ++n < 500) @(posedge ref_clk);
      repeat (40) @(posedge ref_clk);
   endtask
   // Expected decode of the characters the model sends
   function automatic logic [27:0] ent(input logic [9:0] c);
      case (c)
         10'h0FA: ent = {2'b01, 8'h05, c};
         10'h2AA: ent = {2'b00, 8'hB5, c};
         default: ent = {2'b11, 8'hE0, c};
      endcase
   endfunction
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // ****
   // Tests
   // ****
   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      apb(1'b0, 12'h000, 32'h0);
      chk({27'h0, err}, 28'h0, "ctrl error");
      chk(rd[27:0], 28'h0, "ctrl reset");
      apb(1'b0, 12'hFFC, 32'h0);
      chk({27'h0, err}, 28'h1, "unmapped error");
      apb(1'b1, 12'h000, 32'h1);
      repeat (30) @(posedge ref_clk);
      ns = 0;
      // Hunt, comma, data, violation, fill, last comma, data
      send('{10'h2AA, 10'h0FA, 10'h2AA, 10'h000, 10'h0FA, 10'h0FA});
      send('{10'h0FA, 10'h2AA, 10'h2AA, 10'h2AA, 10'h2AA, 10'h2AA});
      chk({27'h0, ns >= 6}, 28'h1, "encoded strobes");
      foreach (seen[i])
         if (i < 6)
            chk(seen[i], ent((i == 0 || i == 3) ? 10'h0FA : i == 2 ? 10'h000 : 10'h2AA), "strobed char");
      $display("test encoded done");
      apb(1'b1, 12'h000, 32'h3);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd[27:0], 28'h3, "ctrl readback");
      repeat (30) @(posedge ref_clk);
      ns = 0;
      send('{10'h2AA, 10'h0FA, 10'h2AA, 10'h0FA, 10'h0FA, 10'h2AA});
      chk(ns, 3, "bypass strobes");
      for (int i = 0; i < 3; i++)
         chk(seen[i][17:0], {8'h00, 10'h0FA}, "bypass raw");
      $display("test bypass done");
      tally_and_finish();
   end
   initial
   begin
      repeat (4000) @(posedge ref_clk);
      err_count++;
      tally_and_finish();
   end
endmodule // tb
